// ### src/asb_consts.vh
// constants for the alu, shift and branch execution subset
`ifndef ASB_CONSTS_VH
`define ASB_CONSTS_VH
// operation codes
`define ASB_OP_NONE    3'h0
`define ASB_OP_ADD_WITH_CARRY_OP    3'h1
`define ASB_OP_ASR1    3'h2
`define ASB_OP_ASRN    3'h3
`define ASB_OP_BRANCH  3'h4
`define ASB_OP_BIT_TEST_SKIP_CLEAR_OP    3'h5
// second operand source
`define ASB_SRC_REG    2'h0
`define ASB_SRC_TEN_BIT_LITERAL  2'h1
`define ASB_SRC_FIVE_BIT_LITERAL   2'h2
// branch conditions
`define ASB_CC_C       4'h0
`define ASB_CC_NC      4'h1
`define ASB_CC_Z       4'h2
`define ASB_CC_NZ      4'h3
`define ASB_CC_N       4'h4
`define ASB_CC_NN      4'h5
`define ASB_CC_OV      4'h6
`define ASB_CC_NOV     4'h7
`define ASB_CC_GT      4'h8
`define ASB_CC_GE      4'h9
`define ASB_CC_LT      4'ha
`define ASB_CC_LE      4'hb
`define ASB_CC_GTU     4'hc
`define ASB_CC_GEU     4'hd
`define ASB_CC_LTU     4'he
`define ASB_CC_LEU     4'hf
// status flag positions in the flag vector
`define ASB_FLAG_C     0
`define ASB_FLAG_Z     1
`define ASB_FLAG_OV    2
`define ASB_FLAG_N     3
`define ASB_FLAG_DC    4
`define ASB_FLAGS_RST  5'h00
// cycle costs
`define ASB_CYC_ONE    2'h1
`define ASB_CYC_TWO    2'h2
`define ASB_CYC_THREE  2'h3
`endif

// ### src/asb_cond.v
// branch condition evaluator
`timescale 1ns/1ps
`include "asb_consts.vh"
module asb_cond (
   // condition select and flags
   input  wire [3:0] cond,
   input  wire [4:0] flags,
   // result
   output reg        taken
);
   wire c;
   wire z;
   wire ov;
   wire n;
   assign c  = flags[`ASB_FLAG_C];
   assign z  = flags[`ASB_FLAG_Z];
   assign ov = flags[`ASB_FLAG_OV];
   assign n  = flags[`ASB_FLAG_N];
   // decode the condition code
   always @* begin
      case (cond)
         `ASB_CC_C:   taken = c;
         `ASB_CC_NC:  taken = ~c;
         `ASB_CC_Z:   taken = z;
         `ASB_CC_NZ:  taken = ~z;
         `ASB_CC_N:   taken = n;
         `ASB_CC_NN:  taken = ~n;
         `ASB_CC_OV:  taken = ov;
         `ASB_CC_NOV: taken = ~ov;
         `ASB_CC_GT:  taken = ~z & ~(n ^ ov);
         `ASB_CC_GE:  taken = ~(n ^ ov);
         `ASB_CC_LT:  taken = n ^ ov;
         `ASB_CC_LE:  taken = z | (n ^ ov);
         `ASB_CC_GTU: taken = c & ~z;
         `ASB_CC_GEU: taken = c;
         `ASB_CC_LTU: taken = ~c;
         `ASB_CC_LEU: taken = ~c | z;
         default:     taken = 1'b0;
      endcase
   end
endmodule

// ### src/asb_exec.v
// execution unit: add with carry, arithmetic shifts, branch, bit test skip
//
// Behaviour
// - add with carry sums operands plus carry; sets c, dc, n, ov, z
// - single shift right keeps sign; sets c, n, ov, z; one cycle
// - multi-bit shift by register or literal amount; only n and z change
// - branch costs one cycle not taken, two taken; flags unchanged
// - branch conditions: flags, their inverses, signed and unsigned compares
// - bit test skips next instruction when bit clear; 1, 2 or 3 cycles
`timescale 1ns/1ps
`include "asb_consts.vh"
module asb_exec (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   // instruction from the decoder
   input  wire        op_valid,
   input  wire [2:0]  op_code,
   input  wire [1:0]  src_sel,
   input  wire [15:0] base_operand_reg,
   input  wire [15:0] source_operand_reg,
   input  wire [9:0]  ten_bit_literal,
   input  wire [4:0]  five_bit_literal,
   input  wire [3:0]  branch_cond,
   input  wire [3:0]  bit_sel,
   input  wire        next_is_two_word,
   // results
   output reg  [15:0] destination_reg,
   output reg         dest_we,
   output reg  [4:0]  flags_r,
   output reg         branch_taken_r,
   output reg         skip_r,
   output reg  [1:0]  cycles_r
);
   // next values for the output registers
   reg  [15:0] res_nxt;
   reg         we_nxt;
   reg  [4:0]  flags_nxt;
   reg         take_nxt;
   reg         skip_nxt;
   reg  [1:0]  cyc_nxt;

   // operands and per-operation results
   reg  [15:0] opb;
   reg  [3:0]  amt;
   reg  [16:0] sum;
   reg  [16:0] nib_sum;
   reg         add_ov;
   reg  [15:0] asr1_res;
   reg  [15:0] asrn_res;
   reg         bit_clear;
   reg  [1:0]  skip_cyc;
   wire        carry_in;
   wire        cond_ok;

   // zero test used by several operations
   function is_zero;
      input [15:0] v;
      begin
         is_zero = (v == 16'h0000);
      end
   endfunction

   asb_cond u_cond (
      .cond  (branch_cond),
      .flags (flags_r),
      .taken (cond_ok)
   );

   // one-position arithmetic shift, sign bit copied into the top
   function [15:0] asr_one;
      input [15:0] v;
      begin
         asr_one = {v[15], v[15:1]};
      end
   endfunction

   // word add with carry in; bit 16 is the carry out
   // nibble sums reuse it with the upper operand bits zeroed
   function [16:0] add_word;
      input [15:0] x;
      input [15:0] y;
      input        ci;
      begin
         add_word = {1'b0, x} + {1'b0, y} + {16'h0000, ci};
      end
   endfunction

   // signed overflow: like-signed operands, result of the other sign
   function add_overflow;
      input xs;
      input ys;
      input rs;
      begin
         add_overflow = (xs == ys) & (rs != ys);
      end
   endfunction

   // carry left by the previous operation feeds the add
   assign carry_in = flags_r[`ASB_FLAG_C];

   // second operand: register, or a literal zero-extended to a word
   always @* begin
      case (src_sel)
         `ASB_SRC_TEN_BIT_LITERAL: opb = {6'h00, ten_bit_literal};
         `ASB_SRC_FIVE_BIT_LITERAL:  opb = {11'h000, five_bit_literal};
         default:        opb = source_operand_reg;
      endcase
   end

   // shift amount: low four bits of register or literal
   // limitation: amounts of 16 and above wrap, callers keep them below
   always @* begin
      if (src_sel == `ASB_SRC_FIVE_BIT_LITERAL) begin
         amt = five_bit_literal[3:0];
      end else begin
         amt = source_operand_reg[3:0];
      end
   end

   // add with carry over the full word and over the low nibble
   // the nibble sum carries into bit 4, which is the digit carry
   always @* begin
      sum     = add_word(base_operand_reg, opb, carry_in);
      nib_sum = add_word({12'h000, base_operand_reg[3:0]},
                         {12'h000, opb[3:0]}, carry_in);
      add_ov  = add_overflow(base_operand_reg[15], opb[15], sum[15]);
   end

   // shift results for the single and multi-position forms
   always @* begin
      asr1_res = asr_one(source_operand_reg);
      asrn_res = $signed(base_operand_reg) >>> amt;
   end

   // bit test: a clear bit skips one word, or two for a long successor
   always @* begin
      bit_clear = ~base_operand_reg[bit_sel];
      if (next_is_two_word) begin
         skip_cyc = `ASB_CYC_THREE;
      end else begin
         skip_cyc = `ASB_CYC_TWO;
      end
   end

   // pick the next register values by operation
   always @* begin
      res_nxt   = 16'h0000;
      we_nxt    = 1'b0;
      flags_nxt = flags_r;
      take_nxt  = 1'b0;
      skip_nxt  = 1'b0;
      cyc_nxt   = `ASB_CYC_ONE;
      case (op_code)
         `ASB_OP_ADD_WITH_CARRY_OP: begin
            // all five flags follow the sum
            res_nxt = sum[15:0];
            we_nxt  = 1'b1;
            flags_nxt[`ASB_FLAG_C]  = sum[16];
            flags_nxt[`ASB_FLAG_DC] = nib_sum[4];
            flags_nxt[`ASB_FLAG_N]  = sum[15];
            flags_nxt[`ASB_FLAG_OV] = add_ov;
            flags_nxt[`ASB_FLAG_Z]  = is_zero(sum[15:0]);
         end
         `ASB_OP_ASR1: begin
            // overflow always clears, carry takes the bit shifted out
            res_nxt = asr1_res;
            we_nxt  = 1'b1;
            flags_nxt[`ASB_FLAG_C]  = source_operand_reg[0];
            flags_nxt[`ASB_FLAG_N]  = asr1_res[15];
            flags_nxt[`ASB_FLAG_OV] = 1'b0;
            flags_nxt[`ASB_FLAG_Z]  = is_zero(asr1_res);
         end
         `ASB_OP_ASRN: begin
            // carry, overflow and digit carry keep their values
            res_nxt = asrn_res;
            we_nxt  = 1'b1;
            flags_nxt[`ASB_FLAG_N] = asrn_res[15];
            flags_nxt[`ASB_FLAG_Z] = is_zero(asrn_res);
         end
         `ASB_OP_BRANCH: begin
            // flags pass through untouched, a taken branch costs two
            take_nxt = cond_ok;
            if (cond_ok) begin
               cyc_nxt = `ASB_CYC_TWO;
            end
         end
         `ASB_OP_BIT_TEST_SKIP_CLEAR_OP: begin
            // no flag changes, only the skip and its cost
            skip_nxt = bit_clear;
            if (bit_clear) begin
               cyc_nxt = skip_cyc;
            end
         end
         default: begin
            we_nxt = 1'b0;
         end
      endcase
   end

   // result and flag registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         destination_reg <= 16'h0000;
         dest_we         <= 1'b0;
         flags_r         <= `ASB_FLAGS_RST;
         branch_taken_r  <= 1'b0;
         skip_r          <= 1'b0;
         cycles_r        <= `ASB_CYC_ONE;
      end else if (ce) begin
         dest_we        <= op_valid & we_nxt;
         branch_taken_r <= op_valid & take_nxt;
         skip_r         <= op_valid & skip_nxt;
         if (op_valid) begin
            destination_reg <= res_nxt;
            flags_r         <= flags_nxt;
            cycles_r        <= cyc_nxt;
         end
      end
   end
endmodule

// ### dv/asb_dec_model.sv
// decoder and register file model issuing one instruction at a time
`timescale 1ns/1ps
module asb_dec_model (
   input  logic        clk,
   output logic        op_valid = 1'b0, tw = 1'b0,
   output logic [2:0]  op_code = 3'h0,
   output logic [1:0]  src_sel = 2'h0,
   output logic [15:0] a = 16'h0000, b = 16'h0000,
   output logic [3:0]  cc = 4'h0, bs = 4'h0);
   // hold one edge, then drop and scramble the released operands
   task issue(input [2:0] o, input [1:0] s, input [15:0] x, y,
      input [3:0] c, k, input t);
      @(posedge clk);
      {op_valid, op_code, src_sel, a, b} <= {1'b1, o, s, x, y};
      {cc, bs, tw} <= {c, k, t};
      @(posedge clk);
      op_valid <= 1'b0;
      a <= ~x;
      b <= ~y;
   endtask
endmodule

// ### dv/asb_exec_checker.sv
// port checker for the execution unit
`timescale 1ns/1ps
module asb_exec_checker (
   input logic        clk, rst_n, ce, op_valid, branch_taken_r, skip_r,
   input logic [2:0]  op_code,
   input logic [1:0]  src_sel, cycles_r,
   input logic [15:0] base_operand_reg, source_operand_reg, destination_reg,
   input logic [4:0]  flags_r,
   input logic [3:0]  branch_cond, bit_sel);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire go = ce & op_valid;
   chk_add_with_carry_op_sum: assert property (go && op_code == 3'h1 && src_sel == 2'h0
      |=> destination_reg == $past(base_operand_reg)
      + $past(source_operand_reg) + $past(flags_r[0]))
      else $error("carry add sum wrong");
   chk_asr_sign: assert property (go && op_code == 3'h2 |=>
      destination_reg == {$past(source_operand_reg[15]),
      $past(source_operand_reg[15:1])}
      && flags_r[0] == $past(source_operand_reg[0]))
      else $error("single shift wrong");
   chk_asrn_keep: assert property (go && op_code == 3'h3 |=>
      ((flags_r ^ $past(flags_r)) & 5'h15) == 5'h00)
      else $error("multi shift touched carry flags");
   chk_branch_cost: assert property (go && op_code == 3'h4 |=>
      cycles_r == (branch_taken_r ? 2'h2 : 2'h1) && $stable(flags_r))
      else $error("branch cost or flags wrong");
   chk_branch_zero: assert property (go && op_code == 3'h4
      && branch_cond == 4'h2 |=> branch_taken_r == $past(flags_r[1]))
      else $error("zero branch decision wrong");
   chk_skip_bit: assert property (go && op_code == 3'h5 |=>
      skip_r == !$past(base_operand_reg[bit_sel])
      && (cycles_r > 2'h1) == skip_r)
      else $error("bit test skip wrong");
   chk_add_with_carry_op_carry: assert property (go && op_code == 3'h1
      && src_sel == 2'h0 |=> flags_r[0] ==
      (({1'b0, $past(base_operand_reg)} + $past(source_operand_reg)
      + $past(flags_r[0])) > 17'h0ffff))
      else $error("carry add carry out wrong");
   chk_branch_signed: assert property (go && op_code == 3'h4
      && branch_cond == 4'h9
      |=> branch_taken_r == ($past(flags_r[3]) == $past(flags_r[2])))
      else $error("signed branch decision wrong");
endmodule
bind asb_exec asb_exec_checker i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
   .op_valid(op_valid), .branch_taken_r(branch_taken_r), .skip_r(skip_r),
   .op_code(op_code), .src_sel(src_sel), .cycles_r(cycles_r),
   .base_operand_reg(base_operand_reg), .flags_r(flags_r),
   .source_operand_reg(source_operand_reg), .bit_sel(bit_sel),
   .destination_reg(destination_reg), .branch_cond(branch_cond));

// ### dv/asb_exec_tb.sv
// testbench for the execution unit fed by the decoder model
`timescale 1ns/1ps
module asb_exec_tb;
   logic clk = 0, rst_n = 0, ce = 0, op_valid, tw, dest_we, taken, skip;
   logic [2:0]  op_code;
   logic [1:0]  src_sel, cyc;
   logic [15:0] a, b, dst;
   logic [3:0]  cc, bs;
   logic [4:0]  fl;
   int n_mismatch = 0, checks = 0, tick = 0;
   asb_dec_model i_dec (.clk(clk), .op_valid(op_valid), .tw(tw), .a(a),
      .b(b), .op_code(op_code), .src_sel(src_sel), .cc(cc), .bs(bs));
   asb_exec i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .op_valid(op_valid),
      .op_code(op_code), .src_sel(src_sel), .base_operand_reg(a),
      .source_operand_reg(b), .ten_bit_literal(b[9:0]),
      .five_bit_literal(b[4:0]), .branch_cond(cc), .bit_sel(bs),
      .next_is_two_word(tw), .destination_reg(dst), .dest_we(dest_we),
      .flags_r(fl), .branch_taken_r(taken), .skip_r(skip), .cycles_r(cyc));
   // clock and run limit
   always #2 clk = ~clk;
   always @(posedge clk) if (++tick == 3000) begin
      n_mismatch++;
      wrap_up();
   end
   task check(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task op(input [2:0] o, input [1:0] s, input [15:0] x, y,
      input [3:0] c, k, input t);
      i_dec.issue(o, s, x, y, c, k, t);
      #1;
   endtask
   task t_add_with_carry_op();
      op(3'h1, 2'h0, 16'hffff, 16'h0001, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'h0000, 5'h13, 3'h3});
      op(3'h1, 2'h2, 16'h7fff, 16'hffe0, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'h8000, 5'h1c, 3'h3});
      op(3'h1, 2'h1, 16'h0001, 16'hffff, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'h0400, 5'h10, 3'h3});
      $display("add_with_carry_op done");
   endtask
   task t_shift();
      op(3'h2, 2'h0, 16'h0000, 16'h8001, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'hc000, 5'h19, 3'h3});
      op(3'h3, 2'h0, 16'h8000, 16'h000f, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'hffff, 5'h19, 3'h3});
      op(3'h3, 2'h2, 16'h4000, 16'h000f, 4'h0, 4'h0, 1'b0);
      check({dst, fl, cyc, dest_we}, {16'h0000, 5'h13, 3'h3});
      $display("shift done");
   endtask
   // codes 0..f over flags 13 (c z dc), then 1c (n ov dc) set by an add
   task t_branch();
      logic [15:0] tv;
      logic [4:0]  f;
      logic [8:0]  e;
      logic [20:0] s;
      for (int p = 0; p < 2; p++) begin
         tv = p ? 16'hc35a : 16'haaa5;
         f = p ? 5'h1c : 5'h13;
         for (int i = 0; i < 16; i++) begin
            op(3'h4, 2'h0, 16'h0000, 16'h0000, i[3:0], 4'h0, 1'b0);
            e = {tv[i], f, tv[i] ? 2'h2 : 2'h1, 1'b0};
            check({taken, fl, cyc, dest_we}, e);
         end
         // 7fff+0+c gives n ov dc; ffff+1 brings back c z dc
         op(3'h1, 2'h0, p ? 16'hffff : 16'h7fff, {15'h0000, p[0]},
            4'h0, 4'h0, 1'b0);
         s = p ? {16'h0000, 5'h13} : {16'h8000, 5'h1c};
         check({dst, fl}, s);
      end
      $display("branch done");
   endtask
   task t_skip();
      for (int i = 0; i < 3; i++) begin
         op(3'h5, 2'h0, 16'h0004, 16'h0000, 4'h0, i ? 4'h3 : 4'h2, i[1]);
         check({skip, fl, cyc}, {i != 0, 5'h13, i[1:0] + 2'h1});
      end
      $display("skip done");
   endtask
   // unknown code, frozen clock enable, then a reset in mid-run
   task t_refuse();
      op(3'h6, 2'h0, 16'h1234, 16'h0001, 4'h0, 4'h0, 1'b0);
      check({dest_we, taken, skip, fl, cyc}, {3'h0, 5'h13, 2'h1});
      @(posedge clk) ce <= 1'b0;
      op(3'h1, 2'h0, 16'h1234, 16'h0001, 4'h0, 4'h0, 1'b0);
      check({dst, dest_we, fl, cyc}, {16'h0000, 1'b0, 5'h13, 2'h1});
      @(posedge clk) begin
         ce <= 1'b1;
         rst_n <= 1'b0;
      end
      @(posedge clk) rst_n <= 1'b1;
      #1 check({dst, dest_we, fl, cyc}, {16'h0000, 1'b0, 5'h00, 2'h1});
      $display("refuse done");
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      #1 check({dest_we, taken, skip, fl, cyc}, {8'h00, 2'h1});
      t_add_with_carry_op();
      t_shift();
      t_branch();
      t_skip();
      t_refuse();
      wrap_up();
   end
endmodule
